// ### shared/dram_seq_pkg.sv
// constants and types for the dram access and refresh sequencer
package dram_seq_pkg;
	localparam int ADDR_W     = 8;
	localparam int RFSH_LONG  = 4;
	localparam int RFSH_SHORT = 3;
	localparam logic [2:0] RFSH_CNT_ZERO = 3'h0;
	localparam logic [2:0] RFSH_CNT_ONE  = 3'h1;
	// mux selects for the memory address outputs
	typedef enum logic [1:0] {
		sel_row  = 2'h0,
		sel_col  = 2'h1,
		sel_rfsh = 2'h3
	} addr_sel_t;
	// gray coded refresh sequence
	typedef enum logic [1:0] {
		rf_idle = 2'h0,
		rf_addr = 2'h1,
		rf_ras  = 2'h3,
		rf_end  = 2'h2
	} rfsh_state_t;
endpackage : dram_seq_pkg

// ### verilog/refresh_addr_counter.sv
// refresh row address counter
`timescale 1ns/1ps
module refresh_addr_counter #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// advance after each refresh
	input  wire logic             step,
	output logic      [WIDTH-1:0] row
);
	if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
		$error("refresh_addr_counter: WIDTH out of range");
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			row <= '0;
		end else if (step) begin
			row <= row + WIDTH'(1);
		end
	end
endmodule : refresh_addr_counter

// ### verilog/dram_access_refresh_sequencer.sv
// dram access and refresh sequencer, both clock edges used
`timescale 1ns/1ps
module dram_access_refresh_sequencer #(
	parameter int ADDR_W = dram_seq_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// host access
	input  wire logic                latch_strobe,
	input  wire logic                access_strobe_n,
	input  wire logic [ADDR_W-1:0]   row_addr,
	input  wire logic [ADDR_W-1:0]   col_addr,
	output logic                     ready,
	// static configuration
	input  wire logic                wait_state_option,
	input  wire logic                four_cycle_refresh,
	// refresh timer and request line
	input  wire logic                refresh_tick,
	input  wire logic                refresh_request_line_in,
	output logic                     refresh_request_line_out,
	output logic                     refresh_request_line_oe,
	// memory side
	output logic [ADDR_W-1:0]        mem_addr_out,
	output logic                     ras_n,
	output logic                     cas_n
);
	// wider addresses would need a wider refresh counter; refused at elaboration
	if (ADDR_W < 1 || ADDR_W > 16) begin : g_addr_w_check
		$error("dram_access_refresh_sequencer: ADDR_W out of range");
	end

	// ------------------------------------------------------------
	// configuration capture
	// ------------------------------------------------------------
	// options latched once after reset; later changes are ignored
	logic cfg_wait;
	logic cfg_four;
	logic cfg_taken;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_taken <= 1'b0;
			cfg_wait  <= 1'b0;
			cfg_four  <= 1'b0;
		end else if (!cfg_taken) begin
			cfg_taken <= 1'b1;
			cfg_wait  <= wait_state_option;
			cfg_four  <= four_cycle_refresh;
		end
	end

	// ------------------------------------------------------------
	// host strobe history
	// ------------------------------------------------------------
	logic latch_q;
	logic acx_q;
	logic latch_fall;
	logic latch_rise;
	logic acx_fall;
	logic acx_rise;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			latch_q <= 1'b1;
			acx_q   <= 1'b1;
		end else begin
			latch_q <= latch_strobe;
			acx_q   <= access_strobe_n;
		end
	end

	assign latch_fall = latch_q && !latch_strobe;
	assign latch_rise = !latch_q && latch_strobe;
	assign acx_fall   = acx_q && !access_strobe_n;
	assign acx_rise   = !acx_q && access_strobe_n;

	// ------------------------------------------------------------
	// falling edge: arbitration sample
	// ------------------------------------------------------------
	// the falling edge only samples here; cas_neg, rf_release_neg and rf_addr_neg are the other falling-edge state
	logic neg_latch_low;
	logic neg_req_low;
	logic neg_acx_low;

	always_ff @(negedge clk) begin
		if (!resetn) begin
			neg_latch_low <= 1'b0;
			neg_req_low   <= 1'b0;
			neg_acx_low   <= 1'b0;
		end else begin
			neg_latch_low <= !latch_strobe;
			neg_req_low   <= !refresh_request_line_in;
			neg_acx_low   <= !access_strobe_n;
		end
	end

	// ------------------------------------------------------------
	// refresh request line
	// ------------------------------------------------------------
	logic        req_drive;
	logic        rf_busy;
	dram_seq_pkg::rfsh_state_t rf_state;
	logic [2:0]  rf_cnt;
	logic        rf_done;
	logic        rf_release_neg;

	// external low is picked up and held by our own drive
	always_ff @(posedge clk) begin
		if (!resetn) begin
			req_drive <= 1'b0;
		end else if (rf_done && cfg_four) begin
			req_drive <= 1'b0;
		end else if (refresh_tick || !refresh_request_line_in) begin
			req_drive <= 1'b1;
		end else if (rf_done) begin
			req_drive <= 1'b0;
		end
	end

	// three-cycle mode lets go on the falling edge closing the refresh
	always_ff @(negedge clk) begin
		if (!resetn) begin
			rf_release_neg <= 1'b0;
		end else begin
			rf_release_neg <= (rf_state == dram_seq_pkg::rf_end) && !cfg_four;
		end
	end

	assign refresh_request_line_out = 1'b0;
	assign refresh_request_line_oe  = req_drive && !rf_release_neg;
	assign rf_busy                  = (rf_state != dram_seq_pkg::rf_idle);

	// ------------------------------------------------------------
	// access state
	// ------------------------------------------------------------
	logic pending;
	logic granted;
	logic acc_ras;
	logic acc_cas;
	logic grant_ras_q;
	logic grant_late;
	logic cas_neg;
	logic col_phase;
	logic grant_now;
	logic rfsh_win;

	// arbitration result as seen from the last falling edge
	assign rfsh_win  = neg_req_low && !acc_ras && rf_state == dram_seq_pkg::rf_idle
		&& !(neg_latch_low && !pending);
	assign grant_now = pending && !rf_busy && !rfsh_win;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pending <= 1'b0;
		end else if (latch_rise && !acc_ras) begin
			pending <= 1'b0;
		end else if (grant_now) begin
			pending <= 1'b0;
		end else if (latch_fall && (rf_busy || rfsh_win)) begin
			pending <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc_ras    <= 1'b0;
			granted    <= 1'b0;
			grant_late <= 1'b0;
		end else if (acx_rise || (latch_rise && !granted && access_strobe_n)) begin
			acc_ras <= 1'b0;
			granted <= 1'b0;
		end else if (grant_now) begin
			acc_ras    <= 1'b1;
			granted    <= 1'b1;
			grant_late <= access_strobe_n;
		end else if (latch_fall && !rf_busy && !rfsh_win) begin
			acc_ras <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			grant_ras_q <= 1'b0;
		end else begin
			grant_ras_q <= grant_now;
		end
	end

	// column strobe: access strobe low, grant path honours edge choice
	always_ff @(posedge clk) begin
		if (!resetn) begin
			col_phase <= 1'b0;
			acc_cas   <= 1'b0;
		end else if (access_strobe_n || !acc_ras) begin
			col_phase <= 1'b0;
			acc_cas   <= 1'b0;
		end else if (!col_phase) begin
			col_phase <= 1'b1;
		end else if (!granted || !grant_late) begin
			acc_cas <= 1'b1;
		end
	end

	always_ff @(negedge clk) begin
		if (!resetn) begin
			cas_neg <= 1'b0;
		end else begin
			cas_neg <= granted && grant_late && col_phase && neg_acx_low;
		end
	end

	// ------------------------------------------------------------
	// ready / wait
	// ------------------------------------------------------------
	logic wait_hold;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wait_hold <= 1'b0;
		end else if (latch_fall && (cfg_wait || rf_busy || rfsh_win)) begin
			wait_hold <= 1'b1;
		end else if (granted || pending) begin
			if (!cfg_wait && grant_now) begin
				wait_hold <= 1'b0;
			end else if (cfg_wait && grant_ras_q && !access_strobe_n) begin
				wait_hold <= 1'b0;
			end
		end else if (cfg_wait && !access_strobe_n) begin
			wait_hold <= 1'b0;
		end else if (latch_rise) begin
			wait_hold <= 1'b0;
		end
	end

	// released only by the rising-edge register above
	assign ready = !wait_hold;

	// ------------------------------------------------------------
	// refresh sequence
	// ------------------------------------------------------------
	logic rf_start;
	assign rf_start = rfsh_win && !pending;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rf_state <= dram_seq_pkg::rf_idle;
			rf_cnt   <= dram_seq_pkg::RFSH_CNT_ZERO;
		end else begin
			case (rf_state)
				dram_seq_pkg::rf_idle: begin
					if (rf_start) begin
						rf_state <= dram_seq_pkg::rf_addr;
					end
				end
				dram_seq_pkg::rf_addr: begin
					rf_state <= dram_seq_pkg::rf_ras;
					rf_cnt   <= cfg_four ? 3'(dram_seq_pkg::RFSH_LONG - 2)
						: 3'(dram_seq_pkg::RFSH_SHORT - 2);
				end
				dram_seq_pkg::rf_ras: begin
					if (rf_cnt == dram_seq_pkg::RFSH_CNT_ONE) begin
						rf_state <= dram_seq_pkg::rf_end;
					end
					rf_cnt <= rf_cnt - 3'h1;
				end
				dram_seq_pkg::rf_end: begin
					rf_state <= dram_seq_pkg::rf_idle;
				end
				default: begin
					rf_state <= dram_seq_pkg::rf_idle;
				end
			endcase
		end
	end

	assign rf_done = (rf_state == dram_seq_pkg::rf_end);

	// ------------------------------------------------------------
	// address mux and strobes
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] rf_row;
	logic              rf_addr_neg;

	refresh_addr_counter #(
		.WIDTH (ADDR_W)
	) u_rf_counter (
		.clk    (clk),
		.resetn (resetn),
		.step   (rf_done),
		.row    (rf_row)
	);

	// falling-edge copy of the refresh state holds the refresh address through the row strobe
	always_ff @(negedge clk) begin
		if (!resetn) begin
			rf_addr_neg <= 1'b0;
		end else begin
			rf_addr_neg <= (rf_state == dram_seq_pkg::rf_addr)
				|| (rf_state == dram_seq_pkg::rf_ras);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mem_addr_out <= '0;
		// refresh row goes out at the win, one clock cycle ahead of the refresh row strobe
		end else if (rf_start || rf_addr_neg || rf_state == dram_seq_pkg::rf_addr) begin
			mem_addr_out <= rf_row;
		end else if (col_phase || (!access_strobe_n && acc_ras)) begin
			mem_addr_out <= col_addr;
		end else begin
			mem_addr_out <= row_addr;
		end
	end

	assign ras_n = !(acc_ras || rf_state == dram_seq_pkg::rf_ras);
	assign cas_n = !(acc_cas || cas_neg);
endmodule : dram_access_refresh_sequencer

// ### tb/dram_seq_sva.sv
// assertion checker for the dram access and refresh sequencer
`timescale 1ns/1ps
module dram_seq_sva #(
	parameter int ADDR_W = 8
) (
	// clock, reset and host side
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              latch_strobe,
	input wire logic              access_strobe_n,
	input wire logic [ADDR_W-1:0] col_addr,
	input wire logic              ready,
	input wire logic              wait_state_option,
	input wire logic              four_cycle_refresh,
	// refresh and memory side
	input wire logic              refresh_tick,
	input wire logic              refresh_request_line_in,
	input wire logic              refresh_request_line_oe,
	input wire logic [ADDR_W-1:0] mem_addr_out,
	input wire logic              ras_n,
	input wire logic              cas_n
);
	// levels seen at the other edge, to catch a change on the wrong edge
	logic rdy_f, oe_f, ras_f, oe_r;
	always_ff @(negedge clk) begin
		rdy_f <= ready;
		oe_f <= refresh_request_line_oe;
		ras_f <= ras_n;
	end
	always_ff @(posedge clk) begin
		oe_r <= refresh_request_line_oe;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ----
	// assertions
	// ----
	ready_rise_edge_a:
	assert property (!(ready && !rdy_f)) else $error("ready rose on a falling edge");
	wait_release_a:
	assert property (wait_state_option && refresh_request_line_in && !ras_n
		&& $fell(access_strobe_n) |=> ready) else $error("ready late after access");
	wait_insert_a:
	assert property (wait_state_option && $fell(latch_strobe) |-> ##[1:2] !ready)
		else $error("no wait state after latch strobe");
	row_strobe_start_a:
	assert property ($fell(latch_strobe) && refresh_request_line_in |-> ##[1:2] !ras_n)
		else $error("row strobe missing after latch strobe");
	column_on_cas_a:
	assert property ($fell(cas_n) |-> !$past(access_strobe_n) && mem_addr_out == col_addr)
		else $error("column strobe without column address");
	refresh_addr_first_a:
	assert property ($fell(ras_n) && latch_strobe |-> $stable(mem_addr_out))
		else $error("refresh row strobe before refresh address");
	access_end_a:
	assert property ($rose(access_strobe_n) |=> cas_n)
		else $error("column strobe held after access strobe");
	tick_request_a:
	assert property (refresh_tick && refresh_request_line_in
		|-> ##[1:2] refresh_request_line_oe) else $error("refresh request not driven");
	refresh_ras_edge_a:
	assert property (refresh_request_line_oe |-> ras_n == ras_f)
		else $error("refresh row strobe moved on a falling edge");
	short_release_a:
	assert property (@(negedge clk) disable iff (!resetn)
		!four_cycle_refresh |-> !(oe_r && !refresh_request_line_oe))
		else $error("request line released on a rising edge");
	long_release_a:
	assert property (four_cycle_refresh |-> !(oe_f && !refresh_request_line_oe))
		else $error("request line released on a falling edge");
	cover property (refresh_request_line_oe && !ras_n);
	cover property (wait_state_option && $rose(ready));
	cover property ($fell(latch_strobe) && !refresh_request_line_in);
endmodule : dram_seq_sva

bind dram_access_refresh_sequencer dram_seq_sva #(.ADDR_W(ADDR_W)) sva_i (
	.clk, .resetn, .latch_strobe, .access_strobe_n, .col_addr, .ready,
	.wait_state_option, .four_cycle_refresh, .refresh_tick, .refresh_request_line_in,
	.refresh_request_line_oe, .mem_addr_out, .ras_n, .cas_n);

// ### tb/ext_refresh_party.sv
// outside party sharing the open drain refresh request line
`timescale 1ns/1ps
module ext_refresh_party (
	// clock and command
	input wire logic clk,
	input wire logic pull,
	// open drain drive, high while pulling low
	output logic     pull_oe
);
	initial pull_oe = 1'b0;
	// changes just after the rising edge, well clear of arbitration
	always @(posedge clk) begin
		pull_oe <= #10 pull;
	end
endmodule : ext_refresh_party

// ### tb/tb_dram_access_refresh_sequencer.sv
// self-checking bench for the dram access and refresh sequencer
`timescale 1ns/1ps
module tb_dram_access_refresh_sequencer;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       latch_strobe = 1'b1;
	logic       access_strobe_n = 1'b1;
	logic       wait_state_option = 1'b0;
	logic       four_cycle_refresh = 1'b0;
	logic       refresh_tick = 1'b0;
	logic       ext_pull = 1'b0;
	logic [7:0] row_addr = 8'hA5;
	logic [7:0] col_addr = 8'h3C;
	logic [7:0] mem_addr_out, last_row;
	logic       ready, rq_wire, rq_oe, rq_out, ext_oe, ras_n, cas_n, have_row;
	int         mismatches = 0;
	int         checks_done = 0;
	int         cycles = 0;
	// pull-up on the shared request line
	assign rq_wire = !(rq_oe || ext_oe);
	dram_access_refresh_sequencer dut (.clk(clk), .resetn(resetn),
		.latch_strobe(latch_strobe), .access_strobe_n(access_strobe_n),
		.row_addr(row_addr), .col_addr(col_addr), .ready(ready),
		.wait_state_option(wait_state_option), .four_cycle_refresh(four_cycle_refresh),
		.refresh_tick(refresh_tick), .refresh_request_line_in(rq_wire),
		.refresh_request_line_out(rq_out), .refresh_request_line_oe(rq_oe),
		.mem_addr_out(mem_addr_out), .ras_n(ras_n), .cas_n(cas_n));
	ext_refresh_party far_end (.clk(clk), .pull(ext_pull), .pull_oe(ext_oe));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			final_report();
		end
	end
	// ----
	// helpers
	// ----
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_addr(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_addr
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask : step
	function automatic logic sig(input int k);
		case (k)
			0: return ras_n;
			1: return cas_n;
			default: return rq_oe;
		endcase
	endfunction : sig
	task automatic wait_for(input string what, input int k, input logic v);
		int i;
		i = 0;
		while (sig(k) !== v && i < 12) begin
			step(1);
			i++;
		end
		chk_bit(what, v, sig(k));
	endtask : wait_for
	task automatic do_reset(input logic ws, input logic fc);
		resetn = 1'b0;
		wait_state_option = ws;
		four_cycle_refresh = fc;
		have_row = 1'b0;
		step(6);
		resetn = 1'b1;
		step(2);
		chk_bit("ready", 1'b1, ready);
		chk_bit("ras_n", 1'b1, ras_n);
		chk_bit("cas_n", 1'b1, cas_n);
		chk_bit("request oe", 1'b0, rq_oe);
		$display("test reset done");
	endtask : do_reset
	task automatic end_access();
		access_strobe_n = 1'b1;
		step(2);
		chk_bit("cas_n", 1'b1, cas_n);
		chk_bit("ras_n", 1'b1, ras_n);
		latch_strobe = 1'b1;
		step(2);
	endtask : end_access
	// ----
	// scenarios
	// ----
	task automatic test_access(input logic ws);
		latch_strobe = 1'b0;
		step(2);
		chk_bit("ras_n", 1'b0, ras_n);
		chk_addr("row", row_addr, mem_addr_out);
		chk_bit("ready", !ws, ready);
		access_strobe_n = 1'b0;
		step(1);
		chk_bit("ready", 1'b1, ready);
		wait_for("cas_n", 1, 1'b0);
		chk_addr("column", col_addr, mem_addr_out);
		end_access();
		$display("test access done");
	endtask : test_access
	task automatic test_refresh(input logic fc, input logic ext);
		int i;
		if (ext)
			ext_pull = 1'b1;
		else
			refresh_tick = 1'b1;
		step(1);
		ext_pull = 1'b0;
		refresh_tick = 1'b0;
		wait_for("request oe", 2, 1'b1);
		chk_bit("request line", 1'b0, rq_wire);
		chk_bit("request out", 1'b0, rq_out);
		wait_for("refresh ras_n", 0, 1'b0);
		if (have_row)
			chk_addr("refresh row", last_row + 8'h01, mem_addr_out);
		last_row = mem_addr_out;
		have_row = 1'b1;
		i = 0;
		while (ras_n === 1'b0 && i < 8) begin
			chk_bit("cas_n", 1'b1, cas_n);
			chk_addr("refresh row hold", last_row, mem_addr_out);
			step(1);
			i++;
		end
		// address and end cycles frame the row strobe within the refresh length
		chk_addr("ras low cycles", fc ? 8'h02 : 8'h01, 8'(i));
		wait_for("request oe", 2, 1'b0);
		chk_bit("request line", 1'b1, rq_wire);
		$display("test refresh done");
	endtask : test_refresh
	task automatic test_grant(input logic ws, input logic late);
		refresh_tick = 1'b1;
		step(1);
		refresh_tick = 1'b0;
		wait_for("refresh ras_n", 0, 1'b0);
		col_addr = 8'hC3;
		latch_strobe = 1'b0;
		access_strobe_n = late;
		step(1);
		chk_bit("ready", 1'b0, ready);
		wait_for("refresh ras end", 0, 1'b1);
		chk_bit("ready", 1'b0, ready);
		wait_for("grant ras_n", 0, 1'b0);
		chk_bit("ready", !ws, ready);
		// late access strobe: column strobe comes from the falling edge
		access_strobe_n = 1'b0;
		step(1);
		chk_bit("ready", 1'b1, ready);
		wait_for("cas_n", 1, 1'b0);
		chk_addr("column", col_addr, mem_addr_out);
		end_access();
		$display("test grant done");
	endtask : test_grant
	initial begin
		do_reset(1'b0, 1'b0);
		test_access(1'b0);
		test_refresh(1'b0, 1'b0);
		test_refresh(1'b0, 1'b1);
		test_grant(1'b0, 1'b0);
		test_grant(1'b0, 1'b1);
		do_reset(1'b1, 1'b1);
		test_access(1'b1);
		test_refresh(1'b1, 1'b0);
		test_grant(1'b1, 1'b0);
		final_report();
	end
endmodule : tb_dram_access_refresh_sequencer
